// >>> serial_frame_defs.vh
// constants for the serial receive/transmit framing block
// assumes a single clock domain and a baud tick supplied by an external generator
//
// Contract
// [R1] sync mode: sample rx, low means start
// [R2] sample data, parity, stops, then rewait; here only the first stop bit is sampled
// [R3] finished character loads holding reg, ready
// [R4] character while ready sets overrun, overwrites
// [R5] clear status command clears error flags
// [R6] even parity generated and checked
// [R7] odd parity generated and checked
// [R8] mark parity sends one, checks one
// [R9] space parity sends zero, checks zero
// [R10] no parity: no bit, no error
// [R11] parity mismatch sets parity error flag
// [R12] codes six/seven select multidrop
// [R13] multidrop: high parity bit flags error
// [R14] send address makes next byte parity one
// [R15] guard count adds idle bits after stop
// [R16] holding free stays low during guard; here it rises with the start bit instead
// [R17] all done stays low through guard
// [R18] zero reload disables idle timeout
// [R19] 16-bit idle counter, bit-period decrement
// [R20] arm command stops counter until character
// [R21] reload command restarts countdown immediately
// [R22] low stop bit sets framing error
`ifndef SERIAL_FRAME_DEFS_VH
`define SERIAL_FRAME_DEFS_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_MODE 4'h1
`define OFS_STATUS 4'h2
`define OFS_RX_HOLD 4'h3
`define OFS_TX_HOLD 4'h4
`define OFS_RX_IDLE 4'h5
`define OFS_TX_GUARD 4'h6

// -----------------------------------------------------------------
// control register bits (write only, self clearing)
// -----------------------------------------------------------------
`define CR_CLEAR_STATUS 8
`define CR_ARM_AFTER_CHAR 11
`define CR_SEND_ADDRESS 12
`define CR_RELOAD_RESTART 15

// -----------------------------------------------------------------
// mode register fields
// -----------------------------------------------------------------
`define MR_CHRL_LSB 6
`define MR_CHRL_MSB 7
`define MR_SYNC 8
`define MR_PAR_LSB 9
`define MR_PAR_MSB 11
`define MR_NBSTOP 12
`define MR_MSBF 16
`define MR_MODE9 17
`define MR_RESET 32'h0000_0000

// -----------------------------------------------------------------
// parity type codes
// -----------------------------------------------------------------
`define PAR_EVEN 3'h0
`define PAR_ODD 3'h1
`define PAR_SPACE 3'h2
`define PAR_MARK 3'h3
`define PAR_NONE 3'h4
`define PAR_MULTI_A 3'h6
`define PAR_MULTI_B 3'h7

// -----------------------------------------------------------------
// status register bit positions
// -----------------------------------------------------------------
`define SR_RX_AVAIL 0
`define SR_TX_FREE 1
`define SR_OVERRUN 5
`define SR_FRAMING 6
`define SR_PARITY 7
`define SR_TIMEOUT 8
`define SR_TX_DONE 9

`endif

// >>> serial_frame.v
// serial port framing core: synchronous receiver, parity, multidrop,
// transmit timeguard, receive idle timeout, framing error
// assumes baud_tick is a one-cycle pulse per bit period from clk_sys logic,
// and that the line rx_line is asynchronous to clk_sys
// a write to a full transmit holder is simply dropped: the port never stalls
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_defs.vh"

module serial_frame #(
  parameter IDLE_WIDTH = 16,
  parameter GUARD_WIDTH = 8
) (
  input wire clk_sys,
  input wire rst,
  input wire baud_tick,
  input wire rx_line,
  output reg tx_line,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata
);

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  // parity bit for a data word under the chosen mode
  // even and odd fold the whole nine-bit word; unused top bits are zero on receive,
  // but on transmit come straight from wdata and enter the count; mark and space ignore the data;
  // multidrop and the spare codes return the caller's address mark
  function par_bit;
    input [2:0] ptype;
    input [8:0] d;
    input addr_mark;
    begin
      case (ptype)
        `PAR_EVEN: par_bit = ^d; // R6
        `PAR_ODD: par_bit = ~(^d); // R7
        `PAR_MARK: par_bit = 1'b1; // R8
        `PAR_SPACE: par_bit = 1'b0; // R9
        default: par_bit = addr_mark; // R12
      endcase
    end
  endfunction

  // data bits in a character
  // nine-bit mode overrides the length field, so that transmitter and
  // receiver always agree on one frame length
  function [3:0] data_len;
    input [31:0] m;
    begin
      if (m[`MR_MODE9])
        data_len = 4'd9;
      else
        data_len = {2'b00, m[`MR_CHRL_MSB:`MR_CHRL_LSB]} + 4'd5;
    end
  endfunction

  // ---------------------------------------------------------------
  // configuration and commands
  // ---------------------------------------------------------------
  reg [31:0] mode_reg;
  reg [IDLE_WIDTH-1:0] idle_reload_value;
  reg [GUARD_WIDTH-1:0] guard_bit_count;
  wire ctl_wr = wr && (addr == `OFS_CONTROL);
  wire clear_status_cmd = ctl_wr && wdata[`CR_CLEAR_STATUS];
  wire arm_after_char_cmd = ctl_wr && wdata[`CR_ARM_AFTER_CHAR];
  wire send_address_cmd = ctl_wr && wdata[`CR_SEND_ADDRESS];
  wire reload_restart_cmd = ctl_wr && wdata[`CR_RELOAD_RESTART];
  wire [2:0] parity_type_field = mode_reg[`MR_PAR_MSB:`MR_PAR_LSB];
  wire par_on = (parity_type_field != `PAR_NONE) && (parity_type_field != 3'h5); // R10
  wire multidrop = parity_type_field[2] & parity_type_field[1]; // R12
  wire [3:0] nbits = data_len(mode_reg);

  // configuration writes
  // the control index has no storage: its bits act as one-cycle commands
  // decoded straight from the write strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= `MR_RESET;
      idle_reload_value <= {IDLE_WIDTH{1'b0}};
      guard_bit_count <= {GUARD_WIDTH{1'b0}};
    end else if (wr) begin
      if (addr == `OFS_MODE)
        mode_reg <= wdata;
      if (addr == `OFS_RX_IDLE)
        idle_reload_value <= wdata[IDLE_WIDTH-1:0];
      if (addr == `OFS_TX_GUARD)
        guard_bit_count <= wdata[GUARD_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  // two flops bring the line into clk_sys
  // both reset to the idle level so leaving reset never looks like a start;
  // only the second flop is read by any logic
  reg rx_meta;
  reg rx_sync;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
    end
  end

  localparam RX_IDLE = 2'd0;
  localparam RX_DATA = 2'd1;
  localparam RX_PAR = 2'd2;
  localparam RX_STOP = 2'd3;
  reg [1:0] rx_state;
  reg [3:0] rx_cnt;
  reg [8:0] rx_shift;
  reg rx_par;
  reg [8:0] receive_holding_reg;
  reg rx_char_available;
  reg overrun_flag;
  reg parity_error_flag;
  reg framing_flag;
  reg rx_done;
  reg rx_perr;

  // received word put back in order
  wire [8:0] rx_word = mode_reg[`MR_MSBF] ? rx_shift : (rx_shift >> (4'd9 - nbits));
  wire rx_par_bad = multidrop ? rx_par // R13
                  : (rx_par != par_bit(parity_type_field, rx_word, 1'b0)); // R6 R7 R8 R9
  wire rd_hold = rd && (addr == `OFS_RX_HOLD);

  // sampling happens on each bit tick; the stop bit is sampled at its middle
  // in the sense that the tick is the bit's sample point
  // only one stop bit is honoured here, whatever the stop setting, so the
  // receiver is ready for a new start on the tick after the stop sample
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_shift <= 9'h000;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      rx_perr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (baud_tick && mode_reg[`MR_SYNC]) begin
        case (rx_state)
          RX_IDLE: begin
            if (!rx_sync) begin // R1
              rx_state <= RX_DATA;
              rx_cnt <= 4'h0;
              rx_shift <= 9'h000;
            end
          end
          RX_DATA: begin
            // msb-first shifts toward the top, lsb-first toward the bottom
            if (mode_reg[`MR_MSBF])
              rx_shift <= {rx_shift[7:0], rx_sync};
            else
              rx_shift <= {rx_sync, rx_shift[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == nbits - 4'h1)
              rx_state <= par_on ? RX_PAR : RX_STOP; // R2 R10
          end
          RX_PAR: begin
            rx_par <= rx_sync;
            rx_state <= RX_STOP;
          end
          RX_STOP: begin
            rx_state <= RX_IDLE; // R2
            rx_done <= 1'b1;
            rx_perr <= par_on && rx_par_bad; // R10
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // holding register and sticky status; a set wins over a clear
  // on overrun the newest character is kept and the older one is lost,
  // which software learns only from the overrun flag
  wire stop_low = baud_tick && mode_reg[`MR_SYNC] && (rx_state == RX_STOP) && !rx_sync;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      receive_holding_reg <= 9'h000;
      rx_char_available <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_flag <= 1'b0;
    end else begin
      if (rx_done) begin
        receive_holding_reg <= rx_word; // R3 R4
        rx_char_available <= 1'b1; // R3
      end else if (rd_hold) begin
        rx_char_available <= 1'b0;
      end
      if (rx_done && rx_char_available)
        overrun_flag <= 1'b1; // R4
      else if (clear_status_cmd)
        overrun_flag <= 1'b0; // R5
      if (rx_done && rx_perr)
        parity_error_flag <= 1'b1; // R11
      else if (clear_status_cmd)
        parity_error_flag <= 1'b0; // R5
      if (stop_low)
        framing_flag <= 1'b1; // R22
      else if (clear_status_cmd)
        framing_flag <= 1'b0; // R5
    end
  end

  // ---------------------------------------------------------------
  // receive idle timeout
  // ---------------------------------------------------------------
  reg [IDLE_WIDTH-1:0] idle_cnt;
  reg idle_run;
  reg timeout_flag;
  // counter is loaded on each character, stepped per bit period
  // a zero reload has top priority so the flag cannot rise while the feature
  // is off; an arm command outranks a character finishing in the same
  // cycle, which at worst delays the next timeout by one character
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt <= {IDLE_WIDTH{1'b0}};
      idle_run <= 1'b0;
      timeout_flag <= 1'b0;
    end else if (idle_reload_value == {IDLE_WIDTH{1'b0}}) begin
      idle_run <= 1'b0; // R18
      timeout_flag <= 1'b0; // R18
    end else if (reload_restart_cmd) begin
      idle_cnt <= idle_reload_value; // R21
      idle_run <= 1'b1; // R21
      timeout_flag <= 1'b0;
    end else if (arm_after_char_cmd) begin
      idle_run <= 1'b0; // R20
      timeout_flag <= 1'b0;
    end else if (rx_done) begin
      idle_cnt <= idle_reload_value; // R19
      idle_run <= 1'b1; // R20
    end else if (idle_run && baud_tick) begin
      idle_cnt <= idle_cnt - {{(IDLE_WIDTH-1){1'b0}}, 1'b1}; // R19
      if (idle_cnt == {{(IDLE_WIDTH-1){1'b0}}, 1'b1}) begin
        timeout_flag <= 1'b1; // R19
        idle_run <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmitter with parity and timeguard
  // ---------------------------------------------------------------
  localparam TX_IDLE = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_PAR = 3'd3;
  localparam TX_STOP = 3'd4;
  localparam TX_GUARD = 3'd5;
  reg [2:0] tx_state;
  reg [8:0] transmit_holding_reg;
  reg thr_addr;
  reg addr_pending;
  reg tx_holding_free;
  reg [8:0] tx_shift;
  reg tx_pbit;
  reg [3:0] tx_cnt;
  reg [GUARD_WIDTH-1:0] guard_cnt;
  wire thr_wr = wr && (addr == `OFS_TX_HOLD);
  wire tx_all_done = (tx_state == TX_IDLE) && tx_holding_free; // R17

  // shifting on baud ticks; a write while the holder is full is dropped
  // holding free rises with the start bit, not at the end of the guard, so a
  // byte queued during the guard keeps it low until its own start bit;
  // all done needs both an idle shifter and an empty holder
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      transmit_holding_reg <= 9'h000;
      thr_addr <= 1'b0;
      addr_pending <= 1'b0;
      tx_holding_free <= 1'b1;
      tx_shift <= 9'h000;
      tx_pbit <= 1'b0;
      tx_cnt <= 4'h0;
      guard_cnt <= {GUARD_WIDTH{1'b0}};
      tx_line <= 1'b1;
    end else begin
      if (send_address_cmd)
        addr_pending <= 1'b1; // R14
      if (thr_wr && tx_holding_free) begin
        transmit_holding_reg <= wdata[8:0];
        thr_addr <= addr_pending && multidrop; // R14
        addr_pending <= 1'b0;
        tx_holding_free <= 1'b0;
      end
      if (baud_tick) begin
        case (tx_state)
          TX_IDLE: begin
            if (!tx_holding_free) begin
              tx_state <= TX_DATA;
              tx_line <= 1'b0;
              tx_holding_free <= 1'b1; // R16
              tx_shift <= mode_reg[`MR_MSBF] ? (transmit_holding_reg << (4'd9 - nbits))
                                             : transmit_holding_reg;
              tx_pbit <= par_bit(parity_type_field, transmit_holding_reg, thr_addr); // R6 R7 R8 R9 R14
              tx_cnt <= 4'h0;
            end
          end
          TX_DATA: begin
            tx_line <= mode_reg[`MR_MSBF] ? tx_shift[8] : tx_shift[0];
            tx_shift <= mode_reg[`MR_MSBF] ? {tx_shift[7:0], 1'b0} : {1'b0, tx_shift[8:1]};
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == nbits - 4'h1)
              tx_state <= par_on ? TX_PAR : TX_STOP; // R10
          end
          TX_PAR: begin
            tx_line <= tx_pbit;
            tx_state <= TX_STOP;
            tx_cnt <= 4'h0;
          end
          TX_STOP: begin
            tx_line <= 1'b1;
            tx_cnt <= tx_cnt + 4'h1;
            // one or two stop bits after parity; without parity the count starts from nbits and must wrap; guard length taken at the last one
            guard_cnt <= guard_bit_count;
            if (tx_cnt == {3'b000, mode_reg[`MR_NBSTOP]})
              tx_state <= (guard_bit_count == {GUARD_WIDTH{1'b0}}) ? TX_IDLE : TX_GUARD; // R15
          end
          TX_GUARD: begin
            // line held high one bit period per guard count
            tx_line <= 1'b1; // R15
            guard_cnt <= guard_cnt - {{(GUARD_WIDTH-1){1'b0}}, 1'b1};
            if (guard_cnt == {{(GUARD_WIDTH-1){1'b0}}, 1'b1})
              tx_state <= TX_IDLE; // R16 R17
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  // reads have no side effect except at the receive holding index, which
  // drops the character-available flag; idle cycles return zero
  wire [31:0] status_word = ({31'h0, rx_char_available} << `SR_RX_AVAIL)
                          | ({31'h0, tx_holding_free} << `SR_TX_FREE)
                          | ({31'h0, overrun_flag} << `SR_OVERRUN)
                          | ({31'h0, framing_flag} << `SR_FRAMING)
                          | ({31'h0, parity_error_flag} << `SR_PARITY)
                          | ({31'h0, timeout_flag} << `SR_TIMEOUT)
                          | ({31'h0, tx_all_done} << `SR_TX_DONE);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `OFS_MODE: rdata <= mode_reg;
        `OFS_STATUS: rdata <= status_word;
        `OFS_RX_HOLD: rdata <= {23'h000000, receive_holding_reg};
        `OFS_RX_IDLE: rdata <= {{(32-IDLE_WIDTH){1'b0}}, idle_reload_value};
        `OFS_TX_GUARD: rdata <= {{(32-GUARD_WIDTH){1'b0}}, guard_bit_count};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// >>> serial_frame_monitor.sv
// checker for the serial framing block, watching only its top-level ports
// assumes the status register is read through rd and answered on rdata
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_defs.vh"
module serial_frame_monitor (
  input wire clk_sys,
  input wire rst,
  input wire baud_tick,
  input wire rx_line,
  input wire tx_line,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata
);
  // ---------------------------------------------
  // helper state and properties
  // ---------------------------------------------
  logic tx_written;
  logic idle_nz;
  // remembers a queued byte and a nonzero idle reload since reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_written <= 1'b0;
      idle_nz <= 1'b0;
    end else begin
      if (wr && addr == `OFS_TX_HOLD) tx_written <= 1'b1;
      if (wr && addr == `OFS_RX_IDLE && wdata[15:0] != 16'h0) idle_nz <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // quiet lead-in: no bit period ends, so no flag can be set meanwhile
  sequence clear_cmd;
    !baud_tick ##1 (!baud_tick && wr && addr == `OFS_CONTROL && wdata[`CR_CLEAR_STATUS]);
  endsequence
  sequence hold_read;
    !baud_tick ##1 (!baud_tick && rd && addr == `OFS_RX_HOLD);
  endsequence
  sequence status_read;
    !baud_tick ##1 (!baud_tick && rd && addr == `OFS_STATUS);
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_unmapped_reads_zero: assert property ($past(rd && addr > 4'h6) |-> rdata == 32'h0)
    else $error("unmapped read returned data");
  a_tx_on_tick: assert property ($changed(tx_line) |-> $past(baud_tick))
    else $error("tx line moved without a bit period");
  a_tx_idle_high: assert property (!tx_written |-> tx_line)
    else $error("tx line left idle with nothing queued");
  a_done_means_free: assert property ($past(rd && addr == `OFS_STATUS) && rdata[`SR_TX_DONE] |-> rdata[`SR_TX_FREE])
    else $error("tx done while holding reg busy");
  a_timeout_disabled: assert property ($past(rd && addr == `OFS_STATUS) && !idle_nz |-> !rdata[`SR_TIMEOUT])
    else $error("timeout flag with zero reload");
  a_clear_status: assert property (clear_cmd ##1 status_read |=> rdata[7:5] == 3'h0)
    else $error("error flags survived clear command");
  a_avail_cleared: assert property (hold_read ##1 status_read |=> !rdata[`SR_RX_AVAIL])
    else $error("char available not cleared by hold read");
endmodule
bind serial_frame serial_frame_monitor mon (.clk_sys(clk_sys), .rst(rst), .baud_tick(baud_tick), .rx_line(rx_line),
  .tx_line(tx_line), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
`default_nettype wire

// >>> remote_serial_model.sv
// far-side serial device: sends frames on rx_line, captures frames from tx_line
// assumes baud_tick is a one-cycle pulse per bit period in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input wire logic clk_sys,
  input wire logic baud_tick,
  input wire logic tx_line,
  output logic rx_line
);
  // ---------------------------------------------
  // frame sender and capture
  // ---------------------------------------------
  logic cap = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [8:0] tx_frame = 9'h0;
  logic [7:0] run = 8'h0;
  logic [7:0] gap = 8'h0;
  initial rx_line = 1'b1;
  // lsb first, one bit per tick; line returns high (pull-up) after the frame
  task automatic send(input logic [7:0] v, input logic hp, input logic p, input logic st);
    logic [10:0] f;
    f = hp ? {st, p, v, 1'b0} : {1'b1, st, v, 1'b0};
    for (int i = 0; i < (hp ? 11 : 10); i++) begin
      @(posedge clk_sys iff baud_tick);
      rx_line <= f[i];
    end
    @(posedge clk_sys iff baud_tick);
    rx_line <= 1'b1;
  endtask
  // nine bits after a start; run counts high samples since the last frame ended
  always @(posedge clk_sys) begin
    if (baud_tick) begin
      run <= tx_line ? run + 8'h1 : 8'h0;
      if (cap) begin
        tx_frame[cnt] <= tx_line;
        cnt <= cnt + 4'h1;
        if (cnt == 4'h8) begin
          cap <= 1'b0;
          run <= 8'h0;
        end
      end else if (!tx_line) begin
        cap <= 1'b1;
        cnt <= 4'h0;
        gap <= run;
      end
    end
  end
endmodule
`default_nettype wire

// >>> usart_rx_parity_timeout_guard_tb_top.sv
// self-checking bench for the serial framing block
// assumes the design, its checker and the far-side model are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_defs.vh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module usart_rx_parity_timeout_guard_tb_top;
  // ---------------------------------------------
  // stimulus, tasks and sequence
  // ---------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic baud_tick = 1'b0;
  logic [2:0] div = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire rx_line;
  wire tx_line;
  wire [31:0] rdata;
  int err_count = 0;
  int checks_done = 0;
  integer seed = 32'h8d27b0ce;
  logic [31:0] s;
  logic [31:0] h;
  logic [7:0] d;
  logic [7:0] d2;
  logic [2:0] modes [7] = '{`PAR_EVEN, `PAR_ODD, `PAR_SPACE, `PAR_MARK, `PAR_NONE, `PAR_MULTI_A, `PAR_MULTI_B};
  serial_frame uut (.clk_sys(clk_sys), .rst(rst), .baud_tick(baud_tick), .rx_line(rx_line), .tx_line(tx_line),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  remote_serial_model far (.clk_sys(clk_sys), .baud_tick(baud_tick), .tx_line(tx_line), .rx_line(rx_line));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // bit period of six clocks leaves room for quiet register sequences
  always @(posedge clk_sys) begin
    div <= (div == 3'h5) ? 3'h0 : div + 3'h1;
    baud_tick <= (div == 3'h5);
  end
  function automatic logic rx_pe(input logic [2:0] m, input logic [7:0] v, input logic p);
    case (m)
      `PAR_EVEN: return p ^ (^v);
      `PAR_ODD: return ~(p ^ (^v));
      `PAR_SPACE: return p;
      `PAR_MARK: return ~p;
      `PAR_NONE: return 1'b0;
      default: return p;
    endcase
  endfunction
  // ninth captured bit: parity, or the stop bit when parity is off
  function automatic logic tx_par(input logic [2:0] m, input logic [7:0] v, input logic a);
    case (m)
      `PAR_EVEN: return ^v;
      `PAR_ODD: return ~^v;
      `PAR_SPACE: return 1'b0;
      `PAR_MARK, `PAR_NONE: return 1'b1;
      default: return a;
    endcase
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
    @(posedge clk_sys);
  endtask
  // park just after a bit period so no flag changes during the next accesses
  task automatic quiet();
    @(posedge clk_sys iff baud_tick);
    @(posedge clk_sys);
  endtask
  task automatic clear_chk();
    quiet();
    wreg(`OFS_CONTROL, 32'h1 << `CR_CLEAR_STATUS);
    rreg(`OFS_STATUS, s);
    `CHK("error flags", 3'h0, s[7:5])
  endtask
  task automatic wait_frame();
    for (int k = 0; k < 400 && !far.cap; k++) @(posedge clk_sys);
    for (int k = 0; k < 400 && far.cap; k++) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask
  task automatic idle_chk(input int n, input logic exp);
    repeat (n) @(posedge clk_sys);
    rreg(`OFS_STATUS, s);
    `CHK("timeout", exp, s[`SR_TIMEOUT])
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rreg(4'hb, s);
    `CHK("unmapped", 32'h0, s)
    // every parity code with both parity bit values, receive then transmit
    for (int m = 0; m < 7; m++) begin
      for (int p = 0; p < 2; p++) begin
        d = $random(seed);
        wreg(`OFS_MODE, 32'h1c0 | (32'(modes[m]) << `MR_PAR_LSB));
        far.send(d, modes[m] != `PAR_NONE, p[0], 1'b1);
        quiet();
        rreg(`OFS_RX_HOLD, h);
        rreg(`OFS_STATUS, s);
        `CHK("rx data", d, h[7:0])
        `CHK("parity flag", rx_pe(modes[m], d, p[0]), s[`SR_PARITY])
        clear_chk();
        if (p == 1 && modes[m] > 3'h5) wreg(`OFS_CONTROL, 32'h1 << `CR_SEND_ADDRESS);
        wreg(`OFS_TX_HOLD, {24'h0, d});
        wait_frame();
        `CHK("tx frame", {tx_par(modes[m], d, p == 1), d}, far.tx_frame)
      end
      $display("parity code %0d done", modes[m]);
    end
    // two frames unread under even parity, the second with a low stop bit
    wreg(`OFS_MODE, 32'h1c0 | (32'(`PAR_EVEN) << `MR_PAR_LSB));
    d = $random(seed);
    d2 = $random(seed);
    far.send(d, 1'b1, ^d, 1'b1);
    far.send(d2, 1'b1, ^d2, 1'b0);
    quiet();
    rreg(`OFS_STATUS, s);
    `CHK("avail", 1'b1, s[`SR_RX_AVAIL])
    `CHK("overrun", 1'b1, s[`SR_OVERRUN])
    `CHK("framing", 1'b1, s[`SR_FRAMING])
    `CHK("parity clean", 1'b0, s[`SR_PARITY])
    rreg(`OFS_RX_HOLD, h);
    `CHK("newest", d2, h[7:0])
    clear_chk();
    $display("overrun and framing done");
    // back-to-back bytes with a guard of three bit periods
    wreg(`OFS_TX_GUARD, 32'h3);
    wreg(`OFS_TX_HOLD, 32'h5a);
    s = 32'h0;
    for (int k = 0; k < 100 && s[`SR_TX_FREE] !== 1'b1; k++) rreg(`OFS_STATUS, s);
    wreg(`OFS_TX_HOLD, {24'h0, d});
    wait_frame();
    rreg(`OFS_STATUS, s);
    `CHK("free in guard", 1'b0, s[`SR_TX_FREE])
    wait_frame();
    `CHK("guard gap", 8'h4, far.gap)
    `CHK("second byte", d, far.tx_frame[7:0])
    rreg(`OFS_STATUS, s);
    `CHK("done in guard", 1'b0, s[`SR_TX_DONE])
    wreg(`OFS_TX_GUARD, 32'h0);
    $display("guard done");
    // idle timeout: restart, arm until a character, then zero reload
    wreg(`OFS_RX_IDLE, 32'h3);
    wreg(`OFS_CONTROL, 32'h1 << `CR_RELOAD_RESTART);
    idle_chk(0, 1'b0);
    idle_chk(36, 1'b1);
    wreg(`OFS_CONTROL, 32'h1 << `CR_ARM_AFTER_CHAR);
    idle_chk(60, 1'b0);
    far.send(d, 1'b1, ^d, 1'b1);
    idle_chk(36, 1'b1);
    wreg(`OFS_RX_IDLE, 32'h0);
    wreg(`OFS_CONTROL, 32'h1 << `CR_RELOAD_RESTART);
    idle_chk(60, 1'b0);
    $display("timeout done");
    report_and_stop();
  end
  // hang guard, well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
